// file: srb_defines.svh
/*
 * Offsets, field positions, reset values and sizes of the result flag and
 * buffer control block. Assumes inclusion by bare name from package and modules.
 */
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

// ==========================================================================
// Register offsets
`define SRB_OFS_FLAGS 8'h0a
`define SRB_OFS_RSVD_ELEVEN 8'h0b
`define SRB_OFS_RSVD_TWELVE 8'h0c
`define SRB_OFS_CTL 8'h0d
`define SRB_OFS_RSVD_FOURTEEN 8'h0e

// ==========================================================================
// Result flag register fields
`define SRB_FLG_FIRST_AUX 7
`define SRB_FLG_SECOND_AUX 6
`define SRB_FLG_CELL 5
`define SRB_FLG_RSVD_HI 4
`define SRB_FLG_RSVD_LO 2
`define SRB_FLG_FIRST_THERMAL 1
`define SRB_FLG_SECOND_THERMAL 0

// ==========================================================================
// Buffer control register fields
`define SRB_CTL_ENABLE 7
`define SRB_CTL_SINGLE 6
`define SRB_CTL_TRIG_HI 5
`define SRB_CTL_TRIG_LO 3
`define SRB_CTL_RSVD 2
`define SRB_CTL_FULL 1
`define SRB_CTL_EMPTY 0

// ==========================================================================
// Reset values and sizes
`define SRB_RST_CTL 6'h00
`define SRB_RST_RSVD 8'h00
`define SRB_RST_RSVD_FLAGS 3'h0
`define SRB_RST_RSVD_FOURTEEN 8'h0f
`define SRB_TRIG_STEP 7'h08
`define SRB_CHANNELS 5
`define SRB_RESULT_W 12
`define SRB_BUF_DEPTH 64

`endif

// file: srb_pkg.sv
/*
 * Types shared by the result flag and buffer control block.
 * Assumes srb_defines.svh is on the include path.
 */
`include "srb_defines.svh"

package srb_pkg;
    // ======================================================================
    // Channel codes as delivered with each conversion result
    typedef enum logic [2:0] {
        SRB_FIRST_AUXILIARY_CHANNEL,
        SRB_SECOND_AUXILIARY_CHANNEL,
        SRB_CELL_VOLTAGE_PIN,
        SRB_FIRST_THERMAL_READING,
        SRB_SECOND_THERMAL_READING,
        SRB_OTHER_CHANNEL
    } srb_chan_e;
    typedef logic [`SRB_RESULT_W-1:0] srb_result_t;
    typedef logic [$clog2(`SRB_BUF_DEPTH)-1:0] srb_ptr_t;
    typedef logic [$clog2(`SRB_BUF_DEPTH):0] srb_count_t;
endpackage : srb_pkg

// file: srb_fifo_if.sv
/*
 * Carrier between the control block and its result FIFO.
 * Assumes one clock domain shared by both ends.
 */
interface srb_fifo_if #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 64
);
    localparam int AW = $clog2(DEPTH);
    logic flush;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;

    modport producer (
        output flush, in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, wr_ptr, rd_ptr, count, full, empty
    );
    modport store (
        input flush, in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, wr_ptr, rd_ptr, count, full, empty
    );
endinterface : srb_fifo_if

// file: srb_fifo.sv
/*
 * Flip-flop FIFO of conversion results with flush.
 * Assumes the producer holds flush while buffering is off.
 */
module srb_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 64
) (
    input wire logic clock,
    input wire logic rst_n,
    srb_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // ======================================================================
    // Status and handshakes
    assign f.full = (cnt_q == DEPTH_C);
    assign f.empty = (cnt_q == '0);
    // Full refuses the write so unread results are never overwritten
    assign f.in_ready = !f.full && !f.flush;
    assign f.out_valid = !f.empty && !f.flush;
    assign f.out_data = mem_q[rd_q];
    assign f.wr_ptr = wr_q;
    assign f.rd_ptr = rd_q;
    assign f.count = cnt_q;
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_ready && f.out_valid;

    // ======================================================================
    // Pointers
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (f.flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                wr_d = wr_q + AW'(1);
            end
            if (pop) begin
                rd_d = rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_d = cnt_q + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_d = cnt_q - (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // ======================================================================
    // Storage, no reset needed on data
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= f.in_data;
        end
    end
endmodule : srb_fifo

// file: srb_flag.sv
/*
 * One sticky new-data flag.
 * Assumes set and clear are one-cycle pulses on the same clock.
 */
module srb_flag (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    logic flag_q, flag_d;

    // ======================================================================
    // Set wins so a result landing with its own read is not lost
    always_comb begin
        flag_d = flag_q;
        if (set) begin
            flag_d = 1'b1;
        end else if (clear) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule : srb_flag

// file: srb_result_flags.sv
/*
 * Result availability flags and result buffer control of the measurement
 * converter, with its register file reached through the serial control port.
 * Assumes the serial port decoder, the converter and the result read logic
 * all run on clock and give one-cycle strobes.
 */
// Operation
// - Bit 7 flags a new first auxiliary result until read.
// - Bit 6 flags a new second auxiliary result until read.
// - Bit 5 flags a new cell voltage result until read.
// - Bit 1 flags a new first thermal result until read.
// - Bit 0 flags a new second thermal result until read.
// - Control bit 7 enables buffering; clearing it resets all pointers.
// - Control bit 6 picks continuous (0) or single-shot (1); resets 0.
// - Bits 5 to 3 give trigger level of eight times code plus one.
// - Bit 1 reads one while 64 unread results are held.
// - Bit 0 reads one while buffer is empty; resets to one.
// - Overall new-data flag clears once all data are read.
`include "srb_defines.svh"

module srb_result_flags
    import srb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic result_valid,
    input wire srb_chan_e result_chan,
    input wire srb_result_t result_data,
    output logic result_ready,
    input wire logic [`SRB_CHANNELS-1:0] chan_read,
    output logic new_data_any,
    output logic conv_run,
    output logic buf_trigger,
    input wire logic buf_pop,
    output srb_result_t buf_data,
    output logic buf_data_valid,
    output srb_ptr_t buffer_read_pointer,
    output srb_ptr_t buffer_write_pointer,
    output srb_ptr_t buffer_trigger_pointer
);
    // ======================================================================
    // Declarations
    logic [5:0] ctl_q, ctl_d;
    logic [2:0] rsvd_flags_q, rsvd_flags_d;
    logic [7:0] rsvd11_q, rsvd11_d;
    logic [7:0] rsvd12_q, rsvd12_d;
    logic [7:0] rsvd14_q, rsvd14_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] rd_mux;
    logic [`SRB_CHANNELS-1:0] chan_hit;
    logic [`SRB_CHANNELS-1:0] flags;
    logic buf_en, single_shot;
    logic [2:0] trig_code;
    logic [6:0] trig_level;
    logic shot_done_q, shot_done_d;
    logic trig_q, trig_d;
    logic any_q, any_d;
    srb_ptr_t trig_ptr_q, trig_ptr_d;
    srb_result_t bdata_q, bdata_d;
    logic bvalid_q, bvalid_d;
    logic push;

    srb_fifo_if #(.WIDTH(`SRB_RESULT_W), .DEPTH(`SRB_BUF_DEPTH)) fif ();

    // ======================================================================
    // Control fields
    assign buf_en = ctl_q[`SRB_CTL_ENABLE-2];
    assign single_shot = ctl_q[`SRB_CTL_SINGLE-2];
    assign trig_code = ctl_q[`SRB_CTL_TRIG_HI-2:`SRB_CTL_TRIG_LO-2];
    // Code 0 gives 8, code 7 gives 64
    assign trig_level = 7'({1'b0, trig_code, 3'b000}) + `SRB_TRIG_STEP;

    // ======================================================================
    // Channel decode of incoming results
    always_comb begin
        chan_hit = '0;
        case (result_chan)
            SRB_FIRST_AUXILIARY_CHANNEL: begin
                chan_hit[0] = 1'b1;
            end
            SRB_SECOND_AUXILIARY_CHANNEL: begin
                chan_hit[1] = 1'b1;
            end
            SRB_CELL_VOLTAGE_PIN: begin
                chan_hit[2] = 1'b1;
            end
            SRB_FIRST_THERMAL_READING: begin
                chan_hit[3] = 1'b1;
            end
            SRB_SECOND_THERMAL_READING: begin
                chan_hit[4] = 1'b1;
            end
            default: begin
                chan_hit = '0;
            end
        endcase
    end

    // ======================================================================
    // Per-channel new-data flags
    // Flags only track direct results; in buffer mode they carry no meaning
    for (genvar i = 0; i < `SRB_CHANNELS; i++) begin : g_flag
        srb_flag u_flag (
            .clock(clock),
            .rst_n(rst_n),
            .set(result_valid && !buf_en && chan_hit[i]),
            .clear(chan_read[i]),
            .flag(flags[i])
        );
    end

    // ======================================================================
    // Overall new-data flag
    always_comb begin
        any_d = (|flags) && !buf_en;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            any_q <= 1'b0;
        end else begin
            any_q <= any_d;
        end
    end

    assign new_data_any = any_q;

    // ======================================================================
    // Result buffer
    assign fif.flush = !buf_en;
    assign fif.in_valid = result_valid && buf_en;
    assign fif.in_data = result_data;
    assign fif.out_ready = buf_pop;
    // Full stalls the converter rather than dropping a result
    assign result_ready = !buf_en || fif.in_ready;
    assign push = fif.in_valid && fif.in_ready;

    srb_fifo #(.WIDTH(`SRB_RESULT_W), .DEPTH(`SRB_BUF_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .f(fif.store)
    );

    // ======================================================================
    // Trigger pointer, trigger pulse and single-shot stop
    always_comb begin
        trig_ptr_d = '0;
        trig_d = 1'b0;
        shot_done_d = shot_done_q;
        if (!buf_en) begin
            shot_done_d = 1'b0;
        end else begin
            trig_ptr_d = fif.rd_ptr + trig_level[5:0];
            if (push && (7'(fif.count) + 7'h01 == trig_level)) begin
                trig_d = 1'b1;
                if (single_shot) begin
                    shot_done_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_ptr_q <= '0;
            trig_q <= 1'b0;
            shot_done_q <= 1'b0;
        end else begin
            trig_ptr_q <= trig_ptr_d;
            trig_q <= trig_d;
            shot_done_q <= shot_done_d;
        end
    end

    // Continuous mode runs until full; single-shot halts at the trigger level
    assign conv_run = buf_en && !fif.full && !shot_done_q;
    assign buf_trigger = trig_q;
    assign buffer_read_pointer = fif.rd_ptr;
    assign buffer_write_pointer = fif.wr_ptr;
    assign buffer_trigger_pointer = trig_ptr_q;

    // ======================================================================
    // Buffered result read-out
    always_comb begin
        bdata_d = bdata_q;
        bvalid_d = 1'b0;
        if (buf_pop && fif.out_valid) begin
            bdata_d = fif.out_data;
            bvalid_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bdata_q <= '0;
            bvalid_q <= 1'b0;
        end else begin
            bdata_q <= bdata_d;
            bvalid_q <= bvalid_d;
        end
    end

    assign buf_data = bdata_q;
    assign buf_data_valid = bvalid_q;

    // ======================================================================
    // Register writes
    // Reserved storage is plain; software is trusted to write legal patterns
    always_comb begin
        ctl_d = ctl_q;
        rsvd_flags_d = rsvd_flags_q;
        rsvd11_d = rsvd11_q;
        rsvd12_d = rsvd12_q;
        rsvd14_d = rsvd14_q;
        if (reg_wr) begin
            if (reg_addr == `SRB_OFS_FLAGS) begin
                rsvd_flags_d = reg_wdata[`SRB_FLG_RSVD_HI:`SRB_FLG_RSVD_LO];
            end else if (reg_addr == `SRB_OFS_RSVD_ELEVEN) begin
                rsvd11_d = reg_wdata;
            end else if (reg_addr == `SRB_OFS_RSVD_TWELVE) begin
                rsvd12_d = reg_wdata;
            end else if (reg_addr == `SRB_OFS_CTL) begin
                ctl_d = reg_wdata[7:2];
            end else if (reg_addr == `SRB_OFS_RSVD_FOURTEEN) begin
                rsvd14_d = reg_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `SRB_RST_CTL;
            rsvd_flags_q <= `SRB_RST_RSVD_FLAGS;
            rsvd11_q <= `SRB_RST_RSVD;
            rsvd12_q <= `SRB_RST_RSVD;
            rsvd14_q <= `SRB_RST_RSVD_FOURTEEN;
        end else begin
            ctl_q <= ctl_d;
            rsvd_flags_q <= rsvd_flags_d;
            rsvd11_q <= rsvd11_d;
            rsvd12_q <= rsvd12_d;
            rsvd14_q <= rsvd14_d;
        end
    end

    // ======================================================================
    // Register reads
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == `SRB_OFS_FLAGS) begin
            rd_mux[`SRB_FLG_FIRST_AUX] = flags[0];
            rd_mux[`SRB_FLG_SECOND_AUX] = flags[1];
            rd_mux[`SRB_FLG_CELL] = flags[2];
            rd_mux[`SRB_FLG_RSVD_HI:`SRB_FLG_RSVD_LO] = rsvd_flags_q;
            rd_mux[`SRB_FLG_FIRST_THERMAL] = flags[3];
            rd_mux[`SRB_FLG_SECOND_THERMAL] = flags[4];
        end else if (reg_addr == `SRB_OFS_RSVD_ELEVEN) begin
            rd_mux = rsvd11_q;
        end else if (reg_addr == `SRB_OFS_RSVD_TWELVE) begin
            rd_mux = rsvd12_q;
        end else if (reg_addr == `SRB_OFS_CTL) begin
            rd_mux[7:2] = ctl_q;
            rd_mux[`SRB_CTL_FULL] = fif.full;
            rd_mux[`SRB_CTL_EMPTY] = fif.empty;
        end else if (reg_addr == `SRB_OFS_RSVD_FOURTEEN) begin
            rd_mux = rsvd14_q;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule : srb_result_flags

// file: srb_result_flags_props.sv
/* Checker on the ports of srb_result_flags.
   Assumes one clock domain and the bind at the foot. */
module srb_result_flags_props
    import srb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic result_valid,
    input wire logic result_ready,
    input wire logic [4:0] chan_read,
    input wire logic new_data_any,
    input wire logic conv_run,
    input wire logic buf_trigger,
    input wire logic buf_pop,
    input wire logic buf_data_valid,
    input wire srb_ptr_t buffer_read_pointer,
    input wire srb_ptr_t buffer_write_pointer,
    input wire srb_ptr_t buffer_trigger_pointer
);
    // ======================================================================
    // Sequences
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_read_flags;
        reg_rd && reg_addr == 8'h0a;
    endsequence
    sequence s_all_read;
        chan_read == 5'h1f && !result_valid;
    endsequence
    // ======================================================================
    // Properties
    property p_flags_cleared;
        s_all_read ##[1:2] s_read_flags |=> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0;
    endproperty
    a_flags_cleared: assert property (p_flags_cleared) else $error("flags stay after read out");
    property p_any_follows;
        s_read_flags |=> reg_rdata[7:5] != 3'h0 || reg_rdata[1:0] != 2'h0 || !new_data_any;
    endproperty
    a_any_follows: assert property (p_any_follows) else $error("overall flag without channel flag");
    property p_full_empty;
        reg_rd && reg_addr == 8'h0d |=> !(reg_rdata[1] && reg_rdata[0]);
    endproperty
    a_full_empty: assert property (p_full_empty) else $error("full and empty together");
    property p_refuse_full;
        !result_ready |-> buffer_write_pointer == buffer_read_pointer && !conv_run;
    endproperty
    a_refuse_full: assert property (p_refuse_full) else $error("refusing while not full");
    property p_trig_level;
        ((buffer_trigger_pointer - $past(buffer_read_pointer)) & 6'h07) == 6'h00;
    endproperty
    a_trig_level: assert property (p_trig_level) else $error("trigger pointer off step");
    property p_pop_answer;
        buf_pop && buffer_read_pointer != buffer_write_pointer |=> buf_data_valid;
    endproperty
    a_pop_answer: assert property (p_pop_answer) else $error("pop not answered");
    property p_valid_cause;
        buf_data_valid |-> $past(buf_pop);
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("data valid without pop");
    property p_disable_flush;
        reg_wr && reg_addr == 8'h0d && !reg_wdata[7] |=> ##1
            buffer_read_pointer == 6'h00 && buffer_write_pointer == 6'h00 && buffer_trigger_pointer == 6'h00;
    endproperty
    a_disable_flush: assert property (p_disable_flush) else $error("pointers kept after disable");
    property p_trigger_pulse;
        buf_trigger |=> !buf_trigger;
    endproperty
    a_trigger_pulse: assert property (p_trigger_pulse) else $error("trigger longer than a cycle");
endmodule : srb_result_flags_props

bind srb_result_flags srb_result_flags_props props_u (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid),
    .result_ready(result_ready), .chan_read(chan_read), .new_data_any(new_data_any),
    .conv_run(conv_run), .buf_trigger(buf_trigger), .buf_pop(buf_pop), .buf_data_valid(buf_data_valid),
    .buffer_read_pointer(buffer_read_pointer), .buffer_write_pointer(buffer_write_pointer),
    .buffer_trigger_pointer(buffer_trigger_pointer)
);

// file: srb_host_model.sv
/* Host on the serial control port side: register read and write tasks.
   Assumes strobes are sampled on the rising edge and driven at the falling one. */
module srb_host_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // ======================================================================
    // Register access
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h0a) v[4:2] = 3'h0;
        if (a == 8'h0e) v = 8'h0f;
        if (a == 8'h0b || a == 8'h0c) rd(a, v);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    // Flags are only read by the bench while buffering is off
endmodule : srb_host_model

// file: srb_result_flags_tb.sv
/* Self-checking bench of the result flag and buffer control block.
   Assumes the host model and the checker bound to the design. */
module srb_result_flags_tb;
    import srb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock;
    logic rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd, result_valid, result_ready, new_data_any, conv_run, buf_trigger, buf_pop, buf_data_valid;
    srb_chan_e result_chan;
    srb_result_t result_data, buf_data;
    logic [4:0] chan_read;
    srb_ptr_t rp, wp, tp;
    logic [7:0] fl [6] = '{8'h80, 8'hc0, 8'he0, 8'he2, 8'he3, 8'he3};
    int errors = 0;
    int samples_checked = 0;
    int trig_seen = 0;
    srb_result_flags dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid),
        .result_chan(result_chan), .result_data(result_data), .result_ready(result_ready),
        .chan_read(chan_read), .new_data_any(new_data_any), .conv_run(conv_run), .buf_trigger(buf_trigger),
        .buf_pop(buf_pop), .buf_data(buf_data), .buf_data_valid(buf_data_valid),
        .buffer_read_pointer(rp), .buffer_write_pointer(wp), .buffer_trigger_pointer(tp));
    srb_host_model host_u (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (buf_trigger === 1'b1) trig_seen++;
    // ======================================================================
    // Tasks
    task automatic results;
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        host_u.rd(a, rv);
        chk(n, rv, e);
    endtask : rdc
    task automatic push(input srb_chan_e c, input srb_result_t d);
        @(negedge clock);
        result_valid = 1'b1;
        result_chan = c;
        result_data = d;
        @(negedge clock);
        result_valid = 1'b0;
    endtask : push
    task automatic pop(input logic v, input srb_result_t e);
        @(negedge clock);
        buf_pop = 1'b1;
        @(negedge clock);
        buf_pop = 1'b0;
        chk("buf_data_valid", buf_data_valid, v);
        if (v) chk("buf_data", buf_data, e);
    endtask : pop
    // ======================================================================
    // Watchdog, over nine thousand cycles of headroom
    initial begin
        #1000000;
        errors++;
        results();
    end
    // ======================================================================
    // Tests
    initial begin
        rst_n = 1'b0;
        result_valid = 1'b0;
        result_chan = SRB_FIRST_AUXILIARY_CHANNEL;
        result_data = 12'h000;
        chan_read = 5'h00;
        buf_pop = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rdc(8'h0a, 8'h00, "flags_reset");
        rdc(8'h0d, 8'h01, "ctl_reset");
        rdc(8'h0e, 8'h0f, "rsvd14_reset");
        host_u.wr(8'h20, 8'hff);
        rdc(8'h20, 8'h00, "unmapped");
        // Code 5 is no channel and must leave the flags alone
        for (int c = 0; c < 6; c++) begin
            push(srb_chan_e'(c), 12'(c));
            rdc(8'h0a, fl[c], "flag_set");
        end
        chk("new_data_any", new_data_any, 1'b1);
        host_u.wr(8'h0a, 8'h00);
        rdc(8'h0a, 8'he3, "flags_read_only");
        @(negedge clock);
        chan_read = 5'h1f;
        @(negedge clock);
        chan_read = 5'h00;
        rdc(8'h0a, 8'h00, "flags_cleared");
        chk("new_data_any", new_data_any, 1'b0);
        host_u.wr(8'h0d, 8'h80);
        rdc(8'h0d, 8'h81, "ctl_enabled");
        trig_seen = 0;
        for (int i = 0; i < 8; i++) push(SRB_CELL_VOLTAGE_PIN, 12'h200 + 12'(i));
        repeat (2) @(negedge clock);
        chk("trigger_count", 16'(trig_seen), 16'h0001);
        chk("trig_ptr", tp, 6'h08);
        rdc(8'h0d, 8'h80, "ctl_data");
        for (int i = 0; i < 8; i++) pop(1'b1, 12'h200 + 12'(i));
        pop(1'b0, 12'h000);
        rdc(8'h0d, 8'h81, "ctl_drained");
        // One push past full must be refused, not overwrite
        for (int i = 0; i < 65; i++) push(SRB_FIRST_AUXILIARY_CHANNEL, 12'(i));
        chk("result_ready", result_ready, 1'b0);
        chk("conv_run", conv_run, 1'b0);
        rdc(8'h0d, 8'h82, "ctl_full");
        for (int i = 0; i < 64; i++) pop(1'b1, 12'(i));
        rdc(8'h0d, 8'h81, "ctl_empty");
        host_u.wr(8'h0d, 8'h00);
        // Flush lands one edge after the control write
        @(negedge clock);
        chk("rd_ptr", rp, 6'h00);
        chk("wr_ptr", wp, 6'h00);
        for (int c = 0; c < 8; c++) begin
            host_u.wr(8'h0d, 8'h80 | 8'(c << 3));
            repeat (2) @(negedge clock);
            chk("trig_ptr", tp, 16'((8 * (c + 1)) % 64));
        end
        host_u.wr(8'h0d, 8'h00);
        host_u.wr(8'h0d, 8'hc8);
        chk("conv_run", conv_run, 1'b1);
        trig_seen = 0;
        for (int i = 0; i < 16; i++) push(SRB_SECOND_THERMAL_READING, 12'(i));
        repeat (2) @(negedge clock);
        chk("trigger_count", 16'(trig_seen), 16'h0001);
        chk("conv_run", conv_run, 1'b0);
        rdc(8'h0d, 8'hc8, "ctl_single");
        results();
    end
endmodule : srb_result_flags_tb
